// ==== include/pusa_regs.vh ====
// register map, field layout, reset values and timing for the strobe assignment block
`ifndef PUSA_REGS_VH
`define PUSA_REGS_VH

// --------------------------------------------------------------------
// register indices (byte address is four times the index)
// --------------------------------------------------------------------
`define PUSA_IDX_LDO_LS_SEL 6'h25
`define PUSA_IDX_GPO_SEL 6'h26
`define PUSA_IDX_UNLOCK 6'h10
`define PUSA_IDX_CONTROL 6'h11
`define PUSA_IDX_STATUS 6'h12

// --------------------------------------------------------------------
// reset values and unlock key
// --------------------------------------------------------------------
`define PUSA_RST_LDO_LS_SEL 8'h63
`define PUSA_RST_GPO_SEL 8'h03
`define PUSA_UNLOCK_KEY 8'h5A

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define PUSA_F_LOW 3:0
`define PUSA_F_HIGH 7:4
`define PUSA_CTL_START 0
`define PUSA_CTL_DOWN 1
`define PUSA_CTL_MAN_LDO 4
`define PUSA_CTL_MAN_LS 5
`define PUSA_CTL_MAN_GENERAL_OUTPUT_ONE 6
`define PUSA_CTL_MAN_GENERAL_OUTPUT_THREE 7

// --------------------------------------------------------------------
// step codes and timing
// --------------------------------------------------------------------
`define PUSA_STEP_FIRST 4'h1
`define PUSA_STEP_SEQ_MIN 4'h3
`define PUSA_STEP_LAST 4'hA
`define PUSA_STEP_BACKUP_MAX 4'h2
`define PUSA_CLK_PERIOD_NS 20
`define PUSA_STEP_TIME_NS 2000
// reload of the step interval counter: 2000 ns at 20 ns, less the zero cycle
`define PUSA_STEP_RELOAD 8'h63
`define PUSA_RESP_OKAY 2'h0
`define PUSA_RESP_SLVERR 2'h2

`endif

// ==== logic/pusa_sequencer.v ====
// strobe-select registers and power-up step engine behind an axi4-lite slave
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "pusa_regs.vh"

// Operation
// - codes 3h..Ah enable output at that step
// - other codes leave output outside sequencer
// - register 0x26: general three high, one low
// - reset: general three unsequenced, load switch one step six, others step three
// - strobe-select writes accepted only after unlock
// - steps one, two only while seal clear
module pusa_sequencer
(
    input wire i_clock,
    input wire i_rst,
    input wire i_freshness_seal_flag,
    input wire [7:0] i_s_axi_awaddr,
    input wire i_s_axi_awvalid,
    output reg o_s_axi_awready,
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    input wire i_s_axi_wvalid,
    output reg o_s_axi_wready,
    output reg [1:0] o_s_axi_bresp,
    output reg o_s_axi_bvalid,
    input wire i_s_axi_bready,
    input wire [7:0] i_s_axi_araddr,
    input wire i_s_axi_arvalid,
    output reg o_s_axi_arready,
    output reg [31:0] o_s_axi_rdata,
    output reg [1:0] o_s_axi_rresp,
    output reg o_s_axi_rvalid,
    input wire i_s_axi_rready,
    output reg o_linear_regulator_one_en,
    output reg o_load_switch_one_en,
    output reg o_general_output_one_en,
    output reg o_general_output_three_en,
    output reg [9:0] o_step_strobe
);

// --------------------------------------------------------------------
// state codes
// --------------------------------------------------------------------
localparam [2:0] ST_IDLE = 3'b001; // waiting for a start request
localparam [2:0] ST_RUN = 3'b010; // walking through the steps
localparam [2:0] ST_DONE = 3'b100; // step ten passed; steps one and two are skipped if sealed

// --------------------------------------------------------------------
// storage
// --------------------------------------------------------------------
reg [7:0] ldo_ls_strobe_select; // low: linear reg, high: load switch one
reg [7:0] gpo_strobe_select; // low: general one, high: general three
reg [7:0] control; // start, down and manual enables
reg unlock_armed; // one protected write allowed
reg seal_meta; // first synchroniser stage
reg seal_sync; // seal flag, safe to use
reg [2:0] state; // one-hot sequencer state
reg [3:0] step; // step to issue next
reg [7:0] tick; // cycles until next step
reg [9:0] reached; // steps already issued
reg aw_held; // write address captured
reg w_held; // write data captured
reg [5:0] aw_idx; // captured write index
reg [7:0] w_byte; // captured low data byte
reg w_lane; // low byte lane was enabled
wire [5:0] ar_idx = i_s_axi_araddr[7:2]; // read index
wire [3:0] linear_reg_step_select = ldo_ls_strobe_select[`PUSA_F_LOW];
wire [3:0] load_switch_one_step_select = ldo_ls_strobe_select[`PUSA_F_HIGH];
wire [3:0] general_out_one_step_select = gpo_strobe_select[`PUSA_F_LOW];
wire [3:0] general_out_three_step_select = gpo_strobe_select[`PUSA_F_HIGH];

// --------------------------------------------------------------------
// decode of a step-select code against the issued steps
// --------------------------------------------------------------------
// codes outside 3h..Ah fall back to the manual bit
function out_enable;
    input [3:0] code;
    input [9:0] done;
    input manual;
    begin
        if (code >= `PUSA_STEP_SEQ_MIN && code <= `PUSA_STEP_LAST)
            out_enable = done[code - `PUSA_STEP_FIRST];
        else
            out_enable = manual;
    end
endfunction

// --------------------------------------------------------------------
// seal flag synchroniser
// --------------------------------------------------------------------
// the pin is asynchronous; only the second stage is read
always @(posedge i_clock)
begin
    if (i_rst)
    begin
        seal_meta <= 1'b0;
        seal_sync <= 1'b0;
    end
    else
    begin
        seal_meta <= i_freshness_seal_flag;
        seal_sync <= seal_meta;
    end
end

// --------------------------------------------------------------------
// axi4-lite write channel and register updates
// --------------------------------------------------------------------
// address and data are taken in either order; the response follows both
always @(posedge i_clock)
begin
    if (i_rst)
    begin
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready <= 1'b1;
        o_s_axi_bvalid <= 1'b0;
        o_s_axi_bresp <= `PUSA_RESP_OKAY;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_idx <= 6'h00;
        w_byte <= 8'h00;
        w_lane <= 1'b0;
        ldo_ls_strobe_select <= `PUSA_RST_LDO_LS_SEL;
        gpo_strobe_select <= `PUSA_RST_GPO_SEL;
        control <= 8'h00;
        unlock_armed <= 1'b0;
    end
    else
    begin
        // start and down bits self-clear after one cycle
        control[`PUSA_CTL_START] <= 1'b0;
        control[`PUSA_CTL_DOWN] <= 1'b0;
        if (i_s_axi_awvalid && o_s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_idx <= i_s_axi_awaddr[7:2];
            o_s_axi_awready <= 1'b0;
        end
        if (i_s_axi_wvalid && o_s_axi_wready)
        begin
            w_held <= 1'b1;
            w_byte <= i_s_axi_wdata[7:0];
            w_lane <= i_s_axi_wstrb[0];
            o_s_axi_wready <= 1'b0;
        end
        if (aw_held && w_held && !o_s_axi_bvalid)
        begin
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp <= `PUSA_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            // any write other than the key ends the unlock
            unlock_armed <= 1'b0;
            case (aw_idx)
                `PUSA_IDX_UNLOCK:
                    unlock_armed <= w_lane && (w_byte == `PUSA_UNLOCK_KEY);
                `PUSA_IDX_LDO_LS_SEL:
                    if (!unlock_armed)
                        o_s_axi_bresp <= `PUSA_RESP_SLVERR;
                    else if (w_lane)
                        ldo_ls_strobe_select <= w_byte;
                `PUSA_IDX_GPO_SEL:
                    if (!unlock_armed)
                        o_s_axi_bresp <= `PUSA_RESP_SLVERR;
                    else if (w_lane)
                        gpo_strobe_select <= w_byte;
                `PUSA_IDX_CONTROL:
                    if (w_lane)
                        control <= w_byte;
                // status is read-only; a write is accepted and dropped
                `PUSA_IDX_STATUS: ;
                default: o_s_axi_bresp <= `PUSA_RESP_SLVERR;
            endcase
        end
        if (o_s_axi_bvalid && i_s_axi_bready)
        begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready <= 1'b1;
        end
    end
end

// --------------------------------------------------------------------
// axi4-lite read channel
// --------------------------------------------------------------------
always @(posedge i_clock)
begin
    if (i_rst)
    begin
        o_s_axi_arready <= 1'b1;
        o_s_axi_rvalid <= 1'b0;
        o_s_axi_rdata <= 32'h00000000;
        o_s_axi_rresp <= `PUSA_RESP_OKAY;
    end
    else if (i_s_axi_arvalid && o_s_axi_arready)
    begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rresp <= `PUSA_RESP_OKAY;
        case (ar_idx)
            `PUSA_IDX_LDO_LS_SEL: o_s_axi_rdata <= {24'h000000, ldo_ls_strobe_select};
            `PUSA_IDX_GPO_SEL: o_s_axi_rdata <= {24'h000000, gpo_strobe_select};
            `PUSA_IDX_CONTROL: o_s_axi_rdata <= {24'h000000, control};
            // seal bit is raw state; software decides whether it means anything
            `PUSA_IDX_STATUS: o_s_axi_rdata <= {reached, 13'h0000, unlock_armed,
                seal_sync, state, step};
            `PUSA_IDX_UNLOCK: o_s_axi_rdata <= 32'h00000000;
            default:
            begin
                o_s_axi_rdata <= 32'h00000000;
                o_s_axi_rresp <= `PUSA_RESP_SLVERR;
            end
        endcase
    end
    else if (o_s_axi_rvalid && i_s_axi_rready)
    begin
        o_s_axi_rvalid <= 1'b0;
        o_s_axi_arready <= 1'b1;
    end
end

// --------------------------------------------------------------------
// step engine
// --------------------------------------------------------------------
// one step per interval, strictly ascending; a power-down request
// drops every sequenced step except the backup ones once sealed
always @(posedge i_clock)
begin
    if (i_rst)
    begin
        state <= ST_IDLE;
        step <= `PUSA_STEP_FIRST;
        tick <= 8'h00;
        reached <= 10'h000;
    end
    else if (control[`PUSA_CTL_DOWN])
    begin
        state <= ST_IDLE;
        step <= `PUSA_STEP_FIRST;
        tick <= 8'h00;
        // backup steps stay on while the seal flag is set
        reached <= seal_sync ? (reached & 10'h003) : 10'h000;
    end
    else
    begin
        case (state)
            // a start from idle or after the last step restarts at step one
            ST_IDLE, ST_DONE:
            begin
                if (control[`PUSA_CTL_START])
                begin
                    state <= ST_RUN;
                    step <= `PUSA_STEP_FIRST;
                    tick <= 8'h00;
                end
            end
            ST_RUN:
            begin
                if (tick != 8'h00)
                    tick <= tick - 8'h01;
                else
                begin
                    // steps one and two only run with the seal flag clear
                    if (step > `PUSA_STEP_BACKUP_MAX || !seal_sync)
                        reached[step - `PUSA_STEP_FIRST] <= 1'b1;
                    tick <= `PUSA_STEP_RELOAD;
                    if (step == `PUSA_STEP_LAST)
                        state <= ST_DONE;
                    else
                        step <= step + `PUSA_STEP_FIRST;
                end
            end
            default:
            begin
                state <= ST_IDLE;
            end
        endcase
    end
end

// --------------------------------------------------------------------
// output enables
// --------------------------------------------------------------------
// all outputs read the same issued-step vector, so outputs sharing a
// step switch on in the same cycle
always @(posedge i_clock)
begin
    if (i_rst)
    begin
        o_linear_regulator_one_en <= 1'b0;
        o_load_switch_one_en <= 1'b0;
        o_general_output_one_en <= 1'b0;
        o_general_output_three_en <= 1'b0;
        o_step_strobe <= 10'h000;
    end
    else
    begin
        o_linear_regulator_one_en <= out_enable(linear_reg_step_select, reached,
            control[`PUSA_CTL_MAN_LDO]);
        o_load_switch_one_en <= out_enable(load_switch_one_step_select, reached,
            control[`PUSA_CTL_MAN_LS]);
        o_general_output_one_en <= out_enable(general_out_one_step_select, reached,
            control[`PUSA_CTL_MAN_GENERAL_OUTPUT_ONE]);
        o_general_output_three_en <= out_enable(general_out_three_step_select, reached,
            control[`PUSA_CTL_MAN_GENERAL_OUTPUT_THREE]);
        o_step_strobe <= reached;
    end
end

endmodule // pusa_sequencer
`default_nettype wire

// ==== tb/power_up_strobe_assignment_tb_top.sv ====
// self-checking bench for the strobe assignment block
`timescale 1ns/1ns
`default_nettype none
`include "pusa_regs.vh"
module power_up_strobe_assignment_tb_top;
    // --------------------------------------------------------------------
    // stimulus, outputs and scoreboard
    // --------------------------------------------------------------------
    logic clk = 1'b0, rst = 1'b1, seal = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000, seed = 32'h00009EC7;
    wire awready, wready, bvalid, arready, rvalid, len, lsen, g1en, g3en;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [9:0] strobe;
    logic [33:0] exp_q[$]; // expected {resp, data} per transfer
    int mismatches = 0, checks = 0, lag = 0; // lag: cycles before ready goes high
    localparam logic [7:0] A_KEY = 4 * `PUSA_IDX_UNLOCK, A_CTL = 4 * `PUSA_IDX_CONTROL;
    localparam logic [7:0] A_LDO = 4 * `PUSA_IDX_LDO_LS_SEL, A_GPO = 4 * `PUSA_IDX_GPO_SEL;
    localparam logic [1:0] OK = `PUSA_RESP_OKAY, ERR = `PUSA_RESP_SLVERR;
    always #10 clk = ~clk;
    pusa_sequencer dut (.i_clock(clk), .i_rst(rst), .i_freshness_seal_flag(seal),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
        .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
        .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_linear_regulator_one_en(len),
        .o_load_switch_one_en(lsen), .o_general_output_one_en(g1en),
        .o_general_output_three_en(g3en), .o_step_strobe(strobe));
    // --------------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------------
    task automatic check(input string n, input logic [33:0] s, input logic [33:0] e);
        checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // sequenced codes follow their step, the rest follow the manual bit
    function automatic logic en(input logic [3:0] c, input int k, input logic m);
        return (c >= 4'h3 && c <= 4'hA) ? (c <= k) : m;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        exp_q.push_back({r, 32'h00000000});
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= (lag == 0);
        do
        begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (n >= lag) bready <= 1'b1;
        end
        while (!(bvalid && bready));
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        exp_q.push_back(e);
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= (lag == 0);
        do
        begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (n >= lag) rready <= 1'b1;
        end
        while (!(rvalid && rready));
        rready <= 1'b0;
    endtask
    // program four fields, start, then sample halfway between steps
    task automatic run(input logic [15:0] c, input logic [3:0] m, input logic sl);
        wr(A_CTL, 32'h2, OK);
        wr(A_KEY, `PUSA_UNLOCK_KEY, OK);
        wr(A_LDO, {24'h0, c[7:0]}, OK);
        wr(A_KEY, `PUSA_UNLOCK_KEY, OK);
        wr(A_GPO, {24'h0, c[15:8]}, OK);
        seal <= sl;
        wr(A_CTL, {24'h0, m, 4'h1}, OK);
        for (int k = 1; k <= 10; k++)
        begin
            repeat (k == 1 ? 50 : 100) @(posedge clk);
            check("enables", {len, lsen, g1en, g3en}, {en(c[3:0], k, m[0]),
                en(c[7:4], k, m[1]), en(c[11:8], k, m[2]), en(c[15:12], k, m[3])});
            check("steps", strobe, ((34'h1 << k) - 1) & (sl ? 34'h3FC : 34'h3FF));
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // --------------------------------------------------------------------
    // monitor, watchdog and main sequence
    // --------------------------------------------------------------------
    // each answer on the bus takes the oldest note
    always @(posedge clk)
        if ((bvalid && bready) || (rvalid && rready))
            check("response", bvalid ? {bresp, 32'h0} : {rresp, rdata}, exp_q.pop_front());
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        wrap_up;
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(A_LDO, {OK, 32'h63});
        rd(A_GPO, {OK, 32'h03});
        // status after reset: idle, next step one; the seal bit is only
        // trusted here because the bench models backup supplies present
        rd(8'(4 * `PUSA_IDX_STATUS), {OK, 32'h00000011});
        lag = 4; // slow master exercises held answers
        rd(8'hFC, {ERR, 32'h0});
        wr(A_GPO, 32'h77, ERR);
        lag = 0;
        rd(A_GPO, {OK, 32'h03});
        seed = lfsr(seed);
        wr(A_KEY, `PUSA_UNLOCK_KEY, OK);
        wr(A_GPO, {24'h0, seed[7:0]}, OK);
        wr(A_GPO, ~seed, ERR);
        rd(A_GPO, {OK, 24'h0, seed[7:0]});
        // four runs set every code 0h..Fh once, the last one sealed
        for (int r = 0; r < 4; r++)
        begin
            seed = lfsr(seed);
            run({4'(4 * r + 3), 4'(4 * r + 2), 4'(4 * r + 1), 4'(4 * r)}, seed[3:0], r == 3);
        end
        wrap_up;
    end
endmodule // power_up_strobe_assignment_tb_top
`default_nettype wire

// ==== tb/pusa_checker.sv ====
// concurrent checks on the strobe assignment block ports
`timescale 1ns/1ns
`default_nettype none
// --------------------------------------------------------------------
// checker module
// --------------------------------------------------------------------
module pusa_checker (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_freshness_seal_flag,
    input wire logic i_s_axi_awvalid,
    input wire logic o_s_axi_awready,
    input wire logic i_s_axi_wvalid,
    input wire logic o_s_axi_wready,
    input wire logic [1:0] o_s_axi_bresp,
    input wire logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic [31:0] o_s_axi_rdata,
    input wire logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic [9:0] o_step_strobe
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    AST_RST_CLEAR: assert property ($fell(i_rst) |-> o_step_strobe == 10'h000)
        else $error("steps left set after reset");
    // step ten only after every sequenced step before it
    AST_STEP_ORDER: assert property ($rose(o_step_strobe[9]) |-> &o_step_strobe[8:2])
        else $error("step ten before earlier steps");
    // steps are 100 cycles apart
    AST_STEP_GAP: assert property ($rose(o_step_strobe[3]) |-> $past(o_step_strobe[2], 100)
        && !$past(o_step_strobe[2], 101)) else $error("step four not 100 cycles after three");
    // margin covers the two-flop synchroniser and the output register
    AST_SEAL_HOLD: assert property (i_freshness_seal_flag [*6] |-> !$rose(o_step_strobe[0])
        && !$rose(o_step_strobe[1])) else $error("backup step issued while sealed");
    AST_B_HOLD: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid
        && $stable(o_s_axi_bresp)) else $error("write response dropped early");
    AST_R_HOLD: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid
        && $stable(o_s_axi_rdata)) else $error("read data dropped early");
    AST_R_LAT: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("read answer late");
    AST_B_LAT: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
        && o_s_axi_wready |-> ##2 o_s_axi_bvalid) else $error("write answer late");
    AST_ONE_WRITE: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
        else $error("new write taken while response pending");
endmodule // pusa_checker
bind pusa_sequencer pusa_checker chk (.i_clock, .i_rst, .i_freshness_seal_flag,
    .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
    .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
    .o_s_axi_rvalid, .i_s_axi_rready, .o_step_strobe);
`default_nettype wire
